// ===== hw/dbac_params.svh
// Constants for the DMA bus access control block.
// Assumes a 25 MHz clock; included by the package and the design.
// Functional notes
// - Full-line writes use memory write and invalidate when that enable is set, else plain memory write.
// - Reads reaching a cache line boundary use memory read line when that enable is set, else plain read.
// - Full-line reads use memory read multiple when enabled and aligned, else the read line rule above applies.
// - While transmit is suspended the auto-poll field picks off, 200 us, 800 us or 1600 us polling.
// - The alignment field picks the burst boundary: reserved, 8, 16 or 32 doublewords.
// - The burst length field caps doublewords per transaction: 0 unlimited, 1, 2, 4, 8, 16 or 32.
// - Endian select swaps bytes big-endian only for data buffer transfers, never for descriptors.
// - The skip length field gives the doubleword gap inserted between consecutive descriptors.
// - The arbitration bit gives receive priority when 0 and transmit priority when 1.
// - Writing 1 to soft reset resets all internal hardware except configuration space.
// - The soft reset bit clears itself when the internal reset has finished.
// - The register reads 0x00001000 after reset and its reserved bits are read-only zero.
// - Every transmit poll, demanded or automatic, reads the descriptor and starts if device-owned.
`ifndef DBAC_PARAMS_SVH
`define DBAC_PARAMS_SVH
`define DBAC_OFFSET_CTRL 8'h00
`define DBAC_RESET_VALUE 32'h00001000
`define DBAC_WRITE_MASK 32'h01a6ffff
`define DBAC_BIT_WIE 24
`define DBAC_BIT_RLE 23
`define DBAC_BIT_RME 21
`define DBAC_TAP_HI 18
`define DBAC_TAP_LO 17
`define DBAC_CAL_HI 15
`define DBAC_CAL_LO 14
`define DBAC_PBL_HI 13
`define DBAC_PBL_LO 8
`define DBAC_BIT_ENDIAN 7
`define DBAC_DSL_HI 6
`define DBAC_DSL_LO 2
`define DBAC_BIT_ARB 1
`define DBAC_BIT_SWR 0
`define DBAC_CLK_MHZ 25
`define DBAC_POLL1_US 200
`define DBAC_POLL2_US 800
`define DBAC_POLL3_US 1600
`define DBAC_SWR_CYCLES 8'h10
`define DBAC_CMD_READ 4'h6
`define DBAC_CMD_WRITE 4'h7
`define DBAC_CMD_READ_MULT 4'hc
`define DBAC_CMD_READ_LINE 4'he
`define DBAC_CMD_WRITE_INV 4'hf
`endif

// ===== hw/dbac_pkg.sv
// Types for the DMA bus access control block.
// Assumes dbac_params.svh is on the include path.
`include "dbac_params.svh"
package dbac_pkg;
  typedef enum logic [1:0] {
    DBAC_IDLE = 2'b00,
    DBAC_WAIT = 2'b01,
    DBAC_POLL = 2'b11
  } dbac_poll_e;
  // Request to the bus master: command, boundary, burst cap
  typedef struct packed {
    logic [3:0] command;
    logic [7:0] boundary_dw;
    logic [6:0] burst_dw;
    logic swap;
  } dbac_req_s;
  // Transfer description from the DMA engine
  typedef struct packed {
    logic is_write;
    logic full_line;
    logic reaches_line;
    logic aligned;
    logic is_descriptor;
    logic is_tx;
  } dbac_xfer_s;
endpackage

// ===== hw/dbac_ctrl.sv
// DMA bus access control register and bus-master request shaping.
// Assumes a register port from the PCI target, a DMA engine presenting transfers, and a bus master draining requests.
`timescale 1ns/10ps
`default_nettype none
`include "dbac_params.svh"
module dbac_ctrl #(
  parameter int POLL1_CYCLES = `DBAC_POLL1_US * `DBAC_CLK_MHZ,
  parameter int POLL2_CYCLES = `DBAC_POLL2_US * `DBAC_CLK_MHZ,
  parameter int POLL3_CYCLES = `DBAC_POLL3_US * `DBAC_CLK_MHZ
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_enable,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic tx_poll_demand,
  input wire logic tx_suspended,
  input wire logic tx_request,
  input wire logic rx_request,
  output logic tx_grant,
  output logic rx_grant,
  output logic tx_poll,
  output logic [4:0] descriptor_skip_length,
  output logic soft_reset_active,
  input wire logic xfer_valid,
  output logic xfer_ready,
  input wire dbac_pkg::dbac_xfer_s xfer,
  output logic req_valid,
  input wire logic req_ready,
  output dbac_pkg::dbac_req_s req
);
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [7:0] swr_count;
  logic [7:0] next_swr_count;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  dbac_pkg::dbac_poll_e poll_state;
  dbac_pkg::dbac_poll_e next_poll_state;
  logic [16:0] poll_count;
  logic [16:0] next_poll_count;
  logic poll;
  logic next_poll;
  logic txg;
  logic next_txg;
  logic rxg;
  logic next_rxg;
  dbac_pkg::dbac_req_s buf_q [2];
  dbac_pkg::dbac_req_s next_buf_q [2];
  logic [1:0] buf_count;
  logic [1:0] next_buf_count;
  dbac_pkg::dbac_req_s shaped;
  logic push;
  logic pop;

  function automatic logic [16:0] poll_period(input logic [1:0] sel);
    case (sel)
      2'b01: poll_period = 17'(POLL1_CYCLES);
      2'b10: poll_period = 17'(POLL2_CYCLES);
      default: poll_period = 17'(POLL3_CYCLES);
    endcase
  endfunction

  function automatic logic [6:0] burst_cap(input logic [5:0] burst_length_limit);
    case (burst_length_limit)
      6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20: burst_cap = {1'b0, burst_length_limit};
      default: burst_cap = 7'h00;
    endcase
  endfunction

  // Register file, write and self-clearing soft reset
  always_comb begin
    next_ctrl = ctrl;
    next_swr_count = swr_count;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    if (swr_count != 8'h00) begin
      next_swr_count = swr_count - 8'h01;
      if (swr_count == 8'h01) begin
        next_ctrl[`DBAC_BIT_SWR] = 1'b0;
      end
    end
    if (reg_write && reg_addr == `DBAC_OFFSET_CTRL && swr_count == 8'h00) begin
      next_ctrl = (reg_wdata & `DBAC_WRITE_MASK) | (ctrl & ~`DBAC_WRITE_MASK);
      if (reg_wdata[`DBAC_BIT_SWR]) begin
        next_ctrl = `DBAC_RESET_VALUE | 32'h00000001;
        next_swr_count = `DBAC_SWR_CYCLES;
      end
    end
    if (reg_read) begin
      next_rvalid = 1'b1;
      if (reg_addr == `DBAC_OFFSET_CTRL) begin
        next_rdata = ctrl;
      end else begin
        next_rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= `DBAC_RESET_VALUE;
      swr_count <= 8'h00;
      rdata <= 32'h00000000;
      rvalid <= 1'b0;
    end else if (clock_enable) begin
      ctrl <= next_ctrl;
      swr_count <= next_swr_count;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // Transmit auto-poll timer
  always_comb begin
    next_poll_state = poll_state;
    next_poll_count = poll_count;
    next_poll = 1'b0;
    case (poll_state)
      dbac_pkg::DBAC_IDLE: begin
        if (tx_suspended && ctrl[`DBAC_TAP_HI:`DBAC_TAP_LO] != 2'b00) begin
          next_poll_state = dbac_pkg::DBAC_WAIT;
          next_poll_count = poll_period(ctrl[`DBAC_TAP_HI:`DBAC_TAP_LO]);
        end
      end
      dbac_pkg::DBAC_WAIT: begin
        next_poll_count = poll_count - 17'h00001;
        if (poll_count <= 17'h00001) begin
          next_poll_state = dbac_pkg::DBAC_POLL;
        end
      end
      default: begin
        next_poll = 1'b1;
        next_poll_state = dbac_pkg::DBAC_WAIT;
        next_poll_count = poll_period(ctrl[`DBAC_TAP_HI:`DBAC_TAP_LO]);
      end
    endcase
    if (!tx_suspended || ctrl[`DBAC_TAP_HI:`DBAC_TAP_LO] == 2'b00 || swr_count != 8'h00) begin
      next_poll_state = dbac_pkg::DBAC_IDLE;
      next_poll = 1'b0;
    end
    if (tx_poll_demand && tx_suspended && swr_count == 8'h00) begin
      next_poll = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      poll_state <= dbac_pkg::DBAC_IDLE;
      poll_count <= 17'h00000;
      poll <= 1'b0;
    end else if (clock_enable) begin
      poll_state <= next_poll_state;
      poll_count <= next_poll_count;
      poll <= next_poll;
    end
  end

  // Arbitration between directions
  always_comb begin
    next_txg = 1'b0;
    next_rxg = 1'b0;
    if (swr_count == 8'h00) begin
      if (tx_request && rx_request) begin
        next_txg = ctrl[`DBAC_BIT_ARB];
        next_rxg = !ctrl[`DBAC_BIT_ARB];
      end else begin
        next_txg = tx_request;
        next_rxg = rx_request;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      txg <= 1'b0;
      rxg <= 1'b0;
    end else if (clock_enable) begin
      txg <= next_txg;
      rxg <= next_rxg;
    end
  end

  // Command selection and request shaping
  always_comb begin
    shaped.command = `DBAC_CMD_READ;
    if (xfer.is_write) begin
      shaped.command = (ctrl[`DBAC_BIT_WIE] && xfer.full_line) ? `DBAC_CMD_WRITE_INV : `DBAC_CMD_WRITE;
    end else if (ctrl[`DBAC_BIT_RME] && xfer.full_line && xfer.aligned) begin
      shaped.command = `DBAC_CMD_READ_MULT;
    end else if (ctrl[`DBAC_BIT_RLE] && xfer.reaches_line) begin
      shaped.command = `DBAC_CMD_READ_LINE;
    end
    case (ctrl[`DBAC_CAL_HI:`DBAC_CAL_LO])
      2'b01: shaped.boundary_dw = 8'h08;
      2'b10: shaped.boundary_dw = 8'h10;
      2'b11: shaped.boundary_dw = 8'h20;
      default: shaped.boundary_dw = 8'h00;
    endcase
    shaped.burst_dw = burst_cap(ctrl[`DBAC_PBL_HI:`DBAC_PBL_LO]);
    shaped.swap = ctrl[`DBAC_BIT_ENDIAN] && !xfer.is_descriptor;
  end

  // Two-entry request buffer
  assign push = xfer_valid && xfer_ready;
  assign pop = req_valid && req_ready;
  always_comb begin
    next_buf_q = buf_q;
    next_buf_count = buf_count;
    if (pop) begin
      next_buf_q[0] = buf_q[1];
      next_buf_count = next_buf_count - 2'h1;
    end
    if (push) begin
      next_buf_q[next_buf_count[0]] = shaped;
      next_buf_count = next_buf_count + 2'h1;
    end
    if (swr_count != 8'h00) begin
      next_buf_count = 2'h0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
      buf_count <= 2'h0;
    end else if (clock_enable) begin
      buf_q <= next_buf_q;
      buf_count <= next_buf_count;
    end
  end

  assign reg_rdata = rdata;
  assign reg_rvalid = rvalid;
  assign tx_grant = txg;
  assign rx_grant = rxg;
  assign tx_poll = poll;
  assign descriptor_skip_length = ctrl[`DBAC_DSL_HI:`DBAC_DSL_LO];
  assign soft_reset_active = ctrl[`DBAC_BIT_SWR];
  assign xfer_ready = buf_count != 2'h2 && swr_count == 8'h00;
  assign req_valid = buf_count != 2'h0;
  assign req = buf_q[0];
endmodule
`default_nettype wire

// ===== verification/dbac_ctrl_props.sv
// Port checks for dbac_ctrl, bound into every instance.
// Assumes clock_enable is held high.
`timescale 1ns/10ps
`default_nettype none
module dbac_ctrl_props (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic reg_read,
  input wire logic reg_rvalid,
  input wire logic [31:0] reg_rdata,
  input wire logic tx_request,
  input wire logic rx_request,
  input wire logic tx_grant,
  input wire logic rx_grant,
  input wire logic tx_poll_demand,
  input wire logic tx_suspended,
  input wire logic tx_poll,
  input wire logic soft_reset_active,
  input wire logic req_valid,
  input wire dbac_pkg::dbac_req_s req
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  chk_read_answer: assert property (reg_read ##1 !reg_read |-> reg_rvalid ##1 !reg_rvalid)
    else $error("read answer wrong");
  chk_reserved_zero: assert property (reg_rvalid |-> (reg_rdata & 32'hfe590000) == 32'h0)
    else $error("reserved bit set");
  chk_swr_clear: assert property ($rose(soft_reset_active) |->
    soft_reset_active [*8] ##1 soft_reset_active [*8] ##1 !soft_reset_active) else $error("soft reset length");
  chk_swr_flush: assert property ($rose(soft_reset_active) |=> !req_valid && !tx_grant && !rx_grant)
    else $error("soft reset left activity");
  chk_arb_one: assert property (tx_request && rx_request && !soft_reset_active |=> tx_grant != rx_grant)
    else $error("grant not exclusive");
  chk_poll_demand: assert property (tx_poll_demand && tx_suspended && !soft_reset_active |=> tx_poll)
    else $error("demand not polled");
  chk_poll_stop: assert property (!tx_suspended |=> !tx_poll)
    else $error("poll outside suspend");
  chk_burst_legal: assert property (req_valid |-> req.burst_dw inside {0, 1, 2, 4, 8, 16, 32})
    else $error("burst cap illegal");
  cover property (tx_poll);
  cover property ($rose(soft_reset_active));
  cover property (tx_request && rx_request ##1 tx_grant);
endmodule
bind dbac_ctrl dbac_ctrl_props u_props (.clock(clock), .reset_n(reset_n), .reg_read(reg_read),
  .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata), .tx_request(tx_request), .rx_request(rx_request),
  .tx_grant(tx_grant), .rx_grant(rx_grant), .tx_poll_demand(tx_poll_demand), .tx_suspended(tx_suspended),
  .tx_poll(tx_poll), .soft_reset_active(soft_reset_active), .req_valid(req_valid), .req(req));
`default_nettype wire

// ===== verification/dbac_bus_model.sv
// Bus master stand-in draining shaped requests.
// Mode 0 always ready, 1 ready on a shifting pattern, 2 stalled.
`timescale 1ns/10ps
`default_nettype none
module dbac_bus_model (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [1:0] mode,
  output logic req_ready
);
  logic [7:0] pat;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pat <= 8'h5b;
      req_ready <= 1'b0;
    end else begin
      pat <= {pat[6:0], pat[7] ^ pat[5]};
      req_ready <= (mode == 2'h0) || (mode == 2'h1 && pat[0]);
    end
  end
endmodule
`default_nettype wire

// ===== verification/dbac_ctrl_tb.sv
// Self-checking bench for dbac_ctrl.
// Poll periods shortened to 20, 40 and 80 cycles.
`timescale 1ns/10ps
`default_nettype none
module dbac_ctrl_tb;
  logic clock = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, tx_poll_demand = 1'b0;
  logic tx_suspended = 1'b0, tx_request = 1'b0, rx_request = 1'b0, xfer_valid = 1'b0;
  logic reg_rvalid, tx_grant, rx_grant, tx_poll, soft_reset_active, xfer_ready, req_valid, req_ready;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, ctrl, rd;
  logic [4:0] descriptor_skip_length;
  logic [1:0] mode = 2'h0;
  logic [15:0] lfsr = 16'h20bc;
  logic [5:0] pbls [8] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h05};
  dbac_pkg::dbac_xfer_s xfer = '0;
  dbac_pkg::dbac_req_s req, expq[$];
  int num_errors = 0, n_tests = 0, p1, p2;
  dbac_ctrl #(.POLL1_CYCLES(20), .POLL2_CYCLES(40), .POLL3_CYCLES(80)) u_dut (
    .clock(clock), .reset_n(reset_n), .clock_enable(1'b1), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .tx_poll_demand(tx_poll_demand), .tx_suspended(tx_suspended), .tx_request(tx_request),
    .rx_request(rx_request), .tx_grant(tx_grant), .rx_grant(rx_grant), .tx_poll(tx_poll),
    .descriptor_skip_length(descriptor_skip_length), .soft_reset_active(soft_reset_active),
    .xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .xfer(xfer), .req_valid(req_valid),
    .req_ready(req_ready), .req(req));
  dbac_bus_model u_bus (.clock(clock), .reset_n(reset_n), .mode(mode), .req_ready(req_ready));
  initial begin
    forever #20 clock = ~clock;
  end
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic dbac_pkg::dbac_req_s shape(logic [31:0] c, dbac_pkg::dbac_xfer_s x);
    dbac_pkg::dbac_req_s r;
    if (x.is_write) r.command = (x.full_line && c[24]) ? 4'hf : 4'h7;
    else if (x.full_line && x.aligned && c[21]) r.command = 4'hc;
    else r.command = (x.reaches_line && c[23]) ? 4'he : 4'h6;
    r.boundary_dw = (c[15:14] == 2'h0) ? 8'h00 : 8'h04 << c[15:14];
    r.burst_dw = (c[13:8] inside {0, 1, 2, 4, 8, 16, 32}) ? 7'(c[13:8]) : 7'h00;
    r.swap = c[7] && !x.is_descriptor;
    return r;
  endfunction
  task automatic ck(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask
  task automatic wr(input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= 8'h00;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    ck("rvalid", 32'h1, 32'(reg_rvalid));
    rd = reg_rdata;
  endtask
  task automatic push();
    dbac_pkg::dbac_xfer_s x;
    logic ok;
    x = 6'(rnd());
    xfer_valid <= 1'b1;
    xfer <= x;
    // Ready is judged where it is settled, then the edge takes the word
    do begin
      @(negedge clock);
      ok = xfer_ready;
      @(posedge clock);
    end while (ok !== 1'b1);
    expq.push_back(shape(ctrl, x));
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Handshake seen before the edge that pops the entry
  always @(negedge clock) begin
    if (reset_n && req_valid && req_ready && expq.size() == 0) ck("req extra", 32'h0, 32'h1);
    else if (reset_n && req_valid && req_ready) ck("req", 32'(expq.pop_front()), 32'(req));
  end
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    rd_reg(8'h00);
    ck("reset value", 32'h00001000, rd);
    rd_reg(8'h04);
    ck("unmapped", 32'h0, rd);
    // registers written only while all DMA is idle
    wr(32'hfffffffe);
    ctrl = 32'h01a6fffe;
    rd_reg(8'h00);
    ck("masked", ctrl, rd);
    for (int b = 0; b < 2; b++) begin
      ctrl[1] = b[0];
      wr(ctrl);
      tx_request <= 1'b1;
      rx_request <= 1'b1;
      @(posedge clock);
      #1;
      ck("tx grant", 32'(b), 32'(tx_grant));
      @(posedge clock);
      tx_request <= 1'b0;
      rx_request <= 1'b0;
    end
    for (int t = 0; t < 4; t++) begin
      ctrl[18:17] = 2'(t);
      wr(ctrl);
      tx_suspended <= 1'b1;
      p1 = 0;
      p2 = 0;
      for (int k = 1; k < 200; k++) begin
        @(posedge clock);
        #1;
        if (tx_poll === 1'b1) begin
          p1 = p2;
          p2 = k;
        end
      end
      ck("poll gap", (t == 0) ? 32'h0 : (32'h0a << t) + 32'h1, 32'(p2 - p1));
      @(posedge clock);
      tx_poll_demand <= 1'b1;
      @(posedge clock);
      tx_poll_demand <= 1'b0;
      tx_suspended <= 1'b0;
      #1;
      ck("demand", 32'h1, 32'(tx_poll));
    end
    for (int i = 0; i < 8; i++) begin
      ctrl = {rnd(), rnd()} & 32'h01a0c0fe;
      ctrl[13:8] = pbls[i];
      wr(ctrl);
      rd_reg(8'h00);
      ck("ctrl", ctrl, rd);
      ck("skip", 32'(ctrl[6:2]), 32'(descriptor_skip_length));
      mode <= (i == 0) ? 2'h2 : 2'(rnd() % 2);
      repeat (2) push();
      if (i == 0) begin
        xfer_valid <= 1'b0;
        @(posedge clock);
        ck("full", 32'h0, 32'(xfer_ready));
        mode <= 2'h0;
      end
      repeat (4) push();
      xfer_valid <= 1'b0;
      while (expq.size() != 0) @(posedge clock);
    end
    wr(ctrl | 32'h1);
    #1;
    ck("soft reset", 32'h1, 32'(soft_reset_active));
    wr(32'h00000f00);
    repeat (20) @(posedge clock);
    rd_reg(8'h00);
    ck("after reset", 32'h00001000, rd);
    complete_run();
  end
endmodule
`default_nettype wire
